// *** rtl/cebi_pkg.sv ***
// Package of shared widths, codes and state types for the core external bus interface
package cebi_pkg;
    localparam int          CEBI_ADDR_W     = 34;
    localparam int          CEBI_DATA_W     = 32;
    localparam int          CEBI_LANES      = 4;
    localparam logic [1:0]  CEBI_BLEN_FOUR  = 2'h1;
    localparam logic [1:0]  CEBI_BLEN_RSVD  = 2'h0;
    localparam logic [3:0]  CEBI_BE_RESET   = 4'h0;
    localparam logic [33:0] CEBI_ADDR_RESET = 34'h0;
    localparam logic [31:0] CEBI_DATA_RESET = 32'h0;
    localparam logic [1:0]  CEBI_BEAT_LAST  = 2'h3;

    typedef enum logic [2:0] {
        CEBI_IDLE  = 3'h0,
        CEBI_ADDR  = 3'h1,
        CEBI_DATA  = 3'h3,
        CEBI_SYNC  = 3'h2
    } cebi_state_e;
endpackage

// *** rtl/cebi_bus_if.sv ***
// Interface carrying the external bus between core master and bus target
`timescale 1ns/1ps
interface cebi_bus_if;
    import cebi_pkg::*;
    logic [CEBI_ADDR_W-1:0] bus_word_address;
    logic [CEBI_LANES-1:0]  byte_lane_mask;
    logic                   address_valid_qualifier;
    logic                   write_en;
    logic                   burst_en;
    logic [1:0]             burst_length_code;
    logic [CEBI_DATA_W-1:0] write_data_bus;
    logic                   wait_for_buffers_empty;
    logic                   address_accept_ready;
    logic [CEBI_DATA_W-1:0] read_data_bus;
    logic                   read_data_valid;
    logic                   write_data_ready;
    logic                   read_bus_error;
    logic                   write_bus_error;
    logic                   ext_write_buffers_empty;

    modport master (
        output bus_word_address, byte_lane_mask, address_valid_qualifier, write_en, burst_en,
               burst_length_code, write_data_bus, wait_for_buffers_empty,
        input  address_accept_ready, read_data_bus, read_data_valid, write_data_ready,
               read_bus_error, write_bus_error, ext_write_buffers_empty
    );
    modport target (
        input  bus_word_address, byte_lane_mask, address_valid_qualifier, write_en, burst_en,
               burst_length_code, write_data_bus, wait_for_buffers_empty,
        output address_accept_ready, read_data_bus, read_data_valid, write_data_ready,
               read_bus_error, write_bus_error, ext_write_buffers_empty
    );
endinterface

// *** rtl/cebi_target.sv ***
// Bus target end: small word memory answering reads and writes with one-cycle latency
`timescale 1ns/1ps
module cebi_target
    import cebi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    cebi_bus_if.target      bus,
    input  wire logic       err_inject,
    input  wire logic       buffers_busy
);
    logic [CEBI_DATA_W-1:0] mem_q [16];
    logic                   busy_q, busy_d;
    logic                   wr_q, wr_d;
    logic                   burst_q, burst_d;
    logic [1:0]             beat_q, beat_d;
    logic [3:0]             idx_q, idx_d;
    logic [3:0]             be_q, be_d;
    logic                   rdv_q, rdv_d;
    logic                   wdr_q, wdr_d;
    logic [CEBI_DATA_W-1:0] rdata_q, rdata_d;
    logic                   ewbe_q, ewbe_d;
    logic                   take;

    assign take = bus.address_valid_qualifier && !busy_q;

    always_comb begin
        busy_d  = busy_q;
        wr_d    = wr_q;
        burst_d = burst_q;
        beat_d  = beat_q;
        idx_d   = idx_q;
        be_d    = be_q;
        rdv_d   = 1'b0;
        wdr_d   = 1'b0;
        rdata_d = rdata_q;
        ewbe_d  = ewbe_q;
        if (take) begin
            busy_d  = 1'b1;
            wr_d    = bus.write_en;
            burst_d = bus.burst_en && (bus.burst_length_code == CEBI_BLEN_FOUR);
            beat_d  = 2'h0;
            idx_d   = bus.bus_word_address[3:0];
            be_d    = bus.byte_lane_mask; // Captured only with the qualifier [R2]
        end else if (busy_q) begin
            rdv_d   = !wr_q; // Earliest valid is the edge after acceptance [R4] [R5]
            wdr_d   = wr_q;
            rdata_d = mem_q[idx_q];
            idx_d   = idx_q + 4'h1;
            beat_d  = beat_q + 2'h1;
            if (!burst_q || beat_q == CEBI_BEAT_LAST)
                busy_d = 1'b0;
        end else if (!buffers_busy) begin
            ewbe_d = 1'b1;
        end
        if (wdr_q && buffers_busy)
            ewbe_d = 1'b0; // Drops in the cycle after write ready [R9]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q  <= 1'b0;
            wr_q    <= 1'b0;
            burst_q <= 1'b0;
            beat_q  <= 2'h0;
            idx_q   <= 4'h0;
            be_q    <= CEBI_BE_RESET;
            rdv_q   <= 1'b0;
            wdr_q   <= 1'b0;
            rdata_q <= CEBI_DATA_RESET;
            ewbe_q  <= 1'b1;
        end else begin
            busy_q  <= busy_d;
            wr_q    <= wr_d;
            burst_q <= burst_d;
            beat_q  <= beat_d;
            idx_q   <= idx_d;
            be_q    <= be_d;
            rdv_q   <= rdv_d;
            wdr_q   <= wdr_d;
            rdata_q <= rdata_d;
            ewbe_q  <= ewbe_d;
        end
    end

    // Lane-wise write at the edge where ready is seen; the word index has already moved on by one
    for (genvar l = 0; l < CEBI_LANES; l++) begin : g_lane
        always_ff @(posedge clk) begin
            if (wdr_q && be_q[l])
                mem_q[idx_q - 4'h1][l*8 +: 8] <= bus.write_data_bus[l*8 +: 8];
        end
    end

    assign bus.address_accept_ready    = !busy_q;
    assign bus.read_data_valid         = rdv_q; // Always a defined level [R4]
    assign bus.read_data_bus           = rdata_q;
    assign bus.write_data_ready        = wdr_q;
    assign bus.read_bus_error          = rdv_q && err_inject; // [R7]
    assign bus.write_bus_error         = wdr_q && err_inject; // Valid at the ready edge [R8]
    assign bus.ext_write_buffers_empty = ewbe_q;
endmodule // cebi_target

// *** rtl/cebi_master.sv ***
// Core end of the external bus: issues single and four-beat transactions
`timescale 1ns/1ps
// Functional notes
// R1: Four lane mask bits map bytes low-high
// R2: Lane mask meaningful only with qualifier
// R3: Word address 35:2 valid with qualifier
// R4: Target flags read data, always defined
// R5: Read valid no earlier than next edge
// R6: Write data advances after write ready
// R7: Read error sampled with read valid
// R8: Write error sampled with write ready
// R9: Buffers-empty drops after write ready
// R10: Qualifier marks transaction start, always defined
// R11: Burst code one means four beats
// R12: Wait-for-empty shown while stalled on buffers
// R13: Reset leaves qualifier low, nothing outstanding
module cebi_master
    import cebi_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    cebi_bus_if.master                  bus,
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic                   req_burst,
    input  wire logic                   req_sync,
    input  wire logic [CEBI_ADDR_W-1:0] req_addr,
    input  wire logic [CEBI_LANES-1:0]  req_be,
    input  wire logic [CEBI_DATA_W-1:0] req_wdata,
    output logic                        req_ready,
    output logic                        wdata_take,
    output logic                        rsp_valid,
    output logic [CEBI_DATA_W-1:0]      rsp_rdata,
    output logic                        rsp_error,
    output logic                        rsp_last
);
    // Address phase, held after acceptance except the qualifier
    cebi_state_e            st_q, st_d;
    logic [CEBI_ADDR_W-1:0] addr_q, addr_d;
    logic [CEBI_LANES-1:0]  be_q, be_d;
    logic                   av_q, av_d;
    logic                   wr_q, wr_d;
    logic                   bst_q, bst_d;
    logic [1:0]             blen_q, blen_d;

    // Data phase
    logic [CEBI_DATA_W-1:0] wd_q, wd_d;
    logic [1:0]             beat_q, beat_d;
    logic                   wwbe_q, wwbe_d;

    // Core-side handshakes and responses
    logic                   rdy_q, rdy_d;
    logic                   take_q, take_d;
    logic                   rv_q, rv_d;
    logic [CEBI_DATA_W-1:0] rd_q, rd_d;
    logic                   re_q, re_d;
    logic                   rl_q, rl_d;
    logic                   beat_done;
    logic                   beat_err;

    // Single transfers end at their first beat
    function automatic logic last_beat(input logic burst, input logic [1:0] beat);
        last_beat = !burst || (beat == CEBI_BEAT_LAST);
    endfunction

    // Beat handshake and its error flag, chosen by direction
    assign beat_done = wr_q ? bus.write_data_ready : bus.read_data_valid;
    assign beat_err  = wr_q ? bus.write_bus_error : bus.read_bus_error; // [R7] [R8]

    always_comb begin
        st_d   = st_q;
        addr_d = addr_q;
        be_d   = be_q;
        av_d   = 1'b0;
        wr_d   = wr_q;
        bst_d  = bst_q;
        blen_d = blen_q;
        wd_d   = wd_q;
        beat_d = beat_q;
        wwbe_d = 1'b0;
        rdy_d  = 1'b0;
        take_d = 1'b0;
        rv_d   = 1'b0;
        rd_d   = rd_q;
        re_d   = 1'b0;
        rl_d   = 1'b0;

        // One transaction at a time; a waiting request simply holds req_valid
        case (st_q)
            CEBI_IDLE: begin
                // Sync requests never start a bus cycle
                if (req_valid && req_sync) begin
                    st_d   = CEBI_SYNC;
                    wwbe_d = 1'b1;
                end else if (req_valid) begin
                    st_d   = CEBI_ADDR;
                    av_d   = 1'b1; // Start of a new transaction [R10]
                    addr_d = req_addr; // [R3]
                    be_d   = req_be; // Bit n covers data bits 8n+7:8n [R1]
                    wr_d   = req_write;
                    bst_d  = req_burst;
                    blen_d = req_burst ? CEBI_BLEN_FOUR : CEBI_BLEN_RSVD; // [R11]
                    wd_d   = req_wdata;
                    beat_d = 2'h0;
                end else begin
                    rdy_d = 1'b1;
                end
            end

            CEBI_ADDR: begin
                av_d = !bus.address_accept_ready;
                if (bus.address_accept_ready) begin
                    st_d = CEBI_DATA; // Data beats only after acceptance [R5]
                end
            end

            CEBI_DATA: begin
                // Read data is taken in the beat's own cycle
                if (beat_done) begin
                    rv_d   = 1'b1;
                    rd_d   = bus.read_data_bus;
                    // Error flag belongs to this beat only
                    re_d   = beat_err;
                    beat_d = beat_q + 2'h1;
                    if (last_beat(bst_q, beat_q)) begin
                        st_d = CEBI_IDLE;
                        rl_d = 1'b1;
                    end
                    if (wr_q && !last_beat(bst_q, beat_q)) begin
                        wd_d   = req_wdata; // Next beat's data follows the ready [R6]
                        take_d = 1'b1;
                    end
                end
            end

            CEBI_SYNC: begin
                // No bus cycle here; only the buffers are watched
                wwbe_d = !bus.ext_write_buffers_empty; // Stalled on buffers [R12]
                if (bus.ext_write_buffers_empty) begin
                    st_d = CEBI_IDLE;
                    rv_d = 1'b1;
                    rl_d = 1'b1;
                end
            end

            default: begin
                st_d = CEBI_IDLE;
            end
        endcase
    end

    // Registers only; every bus output comes straight from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= CEBI_IDLE; // Nothing outstanding [R13]
            addr_q <= CEBI_ADDR_RESET;
            be_q   <= CEBI_BE_RESET;
            av_q   <= 1'b0; // [R13]
            wr_q   <= 1'b0;
            bst_q  <= 1'b0;
            blen_q <= CEBI_BLEN_RSVD;
            wd_q   <= CEBI_DATA_RESET;
            beat_q <= 2'h0;
            wwbe_q <= 1'b0;
            rdy_q  <= 1'b0;
            take_q <= 1'b0;
            rv_q   <= 1'b0;
            rd_q   <= CEBI_DATA_RESET;
            re_q   <= 1'b0;
            rl_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            addr_q <= addr_d;
            be_q   <= be_d;
            av_q   <= av_d;
            wr_q   <= wr_d;
            bst_q  <= bst_d;
            blen_q <= blen_d;
            wd_q   <= wd_d;
            beat_q <= beat_d;
            wwbe_q <= wwbe_d;
            rdy_q  <= rdy_d;
            take_q <= take_d;
            rv_q   <= rv_d;
            rd_q   <= rd_d;
            re_q   <= re_d;
            rl_q   <= rl_d;
        end
    end

    // Address-phase fields stay held after acceptance; target must ignore them then [R2]
    assign bus.address_valid_qualifier = av_q; // [R10]
    assign bus.bus_word_address        = addr_q;
    assign bus.byte_lane_mask          = be_q;
    assign bus.write_en                = wr_q;
    assign bus.burst_en                = bst_q;
    assign bus.burst_length_code       = blen_q;
    assign bus.write_data_bus          = wd_q;
    assign bus.wait_for_buffers_empty  = wwbe_q;

    // Core-side responses
    assign req_ready  = rdy_q;
    assign wdata_take = take_q;
    assign rsp_valid  = rv_q;
    assign rsp_rdata  = rd_q;
    assign rsp_error  = re_q;
    assign rsp_last   = rl_q;
endmodule // cebi_master

// *** tb/cebi_chk.sv ***
// Concurrent checks on the bus between core end and target end
`timescale 1ns/1ps
module cebi_chk
    import cebi_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       address_valid_qualifier,
    input wire logic       address_accept_ready,
    input wire logic       write_en,
    input wire logic       burst_en,
    input wire logic [1:0] burst_length_code,
    input wire logic [CEBI_DATA_W-1:0] write_data_bus,
    input wire logic       wait_for_buffers_empty,
    input wire logic       read_data_valid,
    input wire logic       write_data_ready,
    input wire logic       ext_write_buffers_empty
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire accepted = address_valid_qualifier && address_accept_ready;

    // Reset itself is the cause here, so this one is never disabled
    chk_reset_qual_low: assert property (@(posedge clk) disable iff (1'b0) rst |=> !address_valid_qualifier)
        else $error("qualifier high after reset");
    chk_qual_one_shot: assert property (accepted |=> !address_valid_qualifier)
        else $error("qualifier held after acceptance");
    chk_rdval_not_early: assert property (accepted |-> !read_data_valid)
        else $error("read valid at the accepting edge");
    chk_read_answered: assert property (accepted && !write_en |=> ##[0:4] read_data_valid)
        else $error("read never answered");
    chk_write_answered: assert property (accepted && write_en |=> ##[0:4] write_data_ready)
        else $error("write never answered");
    chk_burst_code: assert property (address_valid_qualifier && burst_en |-> burst_length_code == CEBI_BLEN_FOUR)
        else $error("burst code not four beats");
    chk_wdata_held: assert property ($changed(write_data_bus) |-> address_valid_qualifier || $past(write_data_ready))
        else $error("write data moved before write ready");
    chk_ewbe_drop: assert property ($fell(ext_write_buffers_empty) |-> $past(write_data_ready))
        else $error("buffers empty fell without write ready");
    chk_wait_no_bus: assert property (wait_for_buffers_empty |-> !address_valid_qualifier)
        else $error("bus cycle while stalled on buffers");
    chk_wait_release: assert property (wait_for_buffers_empty && ext_write_buffers_empty |=> ##[0:2] !wait_for_buffers_empty)
        else $error("stall outlives empty buffers");
endmodule // cebi_chk

// *** tb/tb_core_external_bus_interface.sv ***
// Self-checking bench joining the core end and the target end of the external bus
`timescale 1ns/1ps
module tb_core_external_bus_interface;
    import cebi_pkg::*;
    typedef struct packed {
        logic                   w;
        logic                   b;
        logic [CEBI_ADDR_W-1:0] a;
        logic [CEBI_LANES-1:0]  be;
        logic [CEBI_DATA_W-1:0] d;
    } cebi_row_s;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   err_inject = 1'b0;
    logic                   buffers_busy = 1'b0;
    logic                   req_valid = 1'b0;
    logic                   req_write = 1'b0;
    logic                   req_burst = 1'b0;
    logic                   req_sync = 1'b0;
    logic [CEBI_ADDR_W-1:0] req_addr = '0;
    logic [CEBI_LANES-1:0]  req_be = '0;
    logic [CEBI_DATA_W-1:0] req_wdata = '0;
    logic                   req_ready, wdata_take, rsp_valid, rsp_error, rsp_last, got_err, saw_wait;
    logic [CEBI_DATA_W-1:0] rsp_rdata;
    logic [CEBI_DATA_W-1:0] got [4];
    int                     n_mismatch = 0;
    int                     checks_done = 0;
    int                     n_beats, done_at;
    // Reads carry the expected word in d; a burst expects d plus the beat index
    cebi_row_s rows [7] = '{
        '{1'b1, 1'b0, 34'h2, 4'hF, 32'h11223344}, '{1'b1, 1'b0, 34'h2, 4'h2, 32'hAABBCCDD},
        '{1'b0, 1'b0, 34'h2, 4'hF, 32'h1122CC44}, '{1'b1, 1'b1, 34'h8, 4'hF, 32'hA0000000},
        '{1'b0, 1'b1, 34'h8, 4'hF, 32'hA0000000}, '{1'b1, 1'b0, 34'h2, 4'h9, 32'h55667788},
        '{1'b0, 1'b0, 34'h2, 4'hF, 32'h5522CC88}};

    cebi_bus_if cebi_bus_if_inst ();
    cebi_master cebi_master_inst (.clk(clk), .rst(rst), .bus(cebi_bus_if_inst), .req_valid(req_valid),
        .req_write(req_write), .req_burst(req_burst), .req_sync(req_sync), .req_addr(req_addr), .req_be(req_be),
        .req_wdata(req_wdata), .req_ready(req_ready), .wdata_take(wdata_take), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .rsp_last(rsp_last));
    cebi_target cebi_target_inst (.clk(clk), .rst(rst), .bus(cebi_bus_if_inst), .err_inject(err_inject),
        .buffers_busy(buffers_busy));
    cebi_chk cebi_chk_inst (.clk(clk), .rst(rst),
        .address_valid_qualifier(cebi_bus_if_inst.address_valid_qualifier),
        .address_accept_ready(cebi_bus_if_inst.address_accept_ready), .write_en(cebi_bus_if_inst.write_en),
        .burst_en(cebi_bus_if_inst.burst_en), .burst_length_code(cebi_bus_if_inst.burst_length_code),
        .write_data_bus(cebi_bus_if_inst.write_data_bus),
        .wait_for_buffers_empty(cebi_bus_if_inst.wait_for_buffers_empty),
        .read_data_valid(cebi_bus_if_inst.read_data_valid), .write_data_ready(cebi_bus_if_inst.write_data_ready),
        .ext_write_buffers_empty(cebi_bus_if_inst.ext_write_buffers_empty));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [CEBI_DATA_W-1:0] g, input logic [CEBI_DATA_W-1:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: data %h, wanted %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, g, e);
        end
    endtask

    // Request is raised only when the core end is idle, so it is taken at the next edge
    task automatic txn(input logic w, input logic b, input logic s, input logic [CEBI_ADDR_W-1:0] a,
                       input logic [CEBI_LANES-1:0] be, input logic [CEBI_DATA_W-1:0] d);
        n_beats = 0;
        got_err = 1'b0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_burst <= b;
        req_sync <= s;
        req_addr <= a;
        req_be <= be;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        req_wdata <= d + 32'h1; // Second burst word must stand before the first write ready
        for (done_at = 0; done_at < 60; done_at++) begin
            @(negedge clk);
            if (done_at == 3) saw_wait = cebi_bus_if_inst.wait_for_buffers_empty;
            if (done_at == 6) buffers_busy <= 1'b0;
            if (wdata_take === 1'b1) req_wdata <= req_wdata + 32'h1;
            if (rsp_valid === 1'b1) begin
                got[n_beats[1:0]] = rsp_rdata;
                got_err |= rsp_error;
                n_beats++;
                if (rsp_last === 1'b1 || s) break;
            end
        end
        if (done_at == 60) begin
            n_mismatch++;
            $display("unexpected at %0t: no response", $time);
            end_of_test();
        end
        @(posedge clk);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_bit(cebi_bus_if_inst.address_valid_qualifier, 1'b0);
        chk_bit(cebi_bus_if_inst.ext_write_buffers_empty, 1'b1);
        foreach (rows[k]) begin
            txn(rows[k].w, rows[k].b, 1'b0, rows[k].a, rows[k].be, rows[k].d);
            chk_bit(n_beats == (rows[k].b ? 4 : 1), 1'b1);
            if (!rows[k].w) begin
                for (int j = 0; j < n_beats; j++) chk_data(got[j], rows[k].d + j);
            end
        end
        err_inject <= 1'b1;
        txn(1'b0, 1'b0, 1'b0, 34'h2, 4'hF, 32'h0);
        chk_bit(got_err, 1'b1);
        txn(1'b1, 1'b0, 1'b0, 34'h4, 4'hF, 32'h0);
        chk_bit(got_err, 1'b1);
        err_inject <= 1'b0;
        txn(1'b0, 1'b0, 1'b0, 34'h2, 4'hF, 32'h0);
        chk_bit(got_err, 1'b0);
        // Buffers stay busy until the sync has had time to stall
        buffers_busy <= 1'b1;
        txn(1'b1, 1'b0, 1'b0, 34'h5, 4'hF, 32'h0);
        @(negedge clk);
        chk_bit(cebi_bus_if_inst.ext_write_buffers_empty, 1'b0);
        txn(1'b0, 1'b0, 1'b1, 34'h0, 4'h0, 32'h0);
        chk_bit(saw_wait, 1'b1);
        chk_bit(done_at > 6, 1'b1);
        rst <= 1'b1;
        req_valid <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk_bit(cebi_bus_if_inst.address_valid_qualifier, 1'b0);
        chk_bit(rsp_valid, 1'b0);
        end_of_test();
    end
endmodule // tb_core_external_bus_interface
